/* hw/gbc_pkg.sv */
// Purpose: Shared constants and state types of the gapped burst clock generator.
// Assumes: Two channels with four pattern generators each.
// Notes: Register indices are multiplied by four to give APB byte addresses.
package gbc_pkg;

	localparam int NCH = 2;
	localparam int NOUT = 4;
	localparam int NG = NCH * NOUT;
	localparam int PHW = 8;
	localparam int POSW = 9;
	localparam int IDXW = 14;

	localparam logic [IDXW-1:0] IDX_GAP [NCH] = '{14'h10d2, 14'h14d2};
	localparam logic [IDXW-1:0] IDX_LEN [NCH] = '{14'h10d3, 14'h14d3};
	localparam logic [IDXW-1:0] IDX_FUNC [NCH] = '{14'h10d4, 14'h14d4};
	localparam logic [IDXW-1:0] IDX_RTC [NCH] = '{14'h10d6, 14'h14d6};
	localparam logic [IDXW-1:0] IDX_REQ [NCH] = '{14'h2101, 14'h2201};
	localparam logic [IDXW-1:0] IDX_STAT [NCH] = '{14'h2102, 14'h2202};

	localparam int LEN_W = 6;
	localparam int MODE_BIT = 6;
	localparam int RETIME_BIT = 0;
	localparam int REQ_BIT = 0;
	localparam int EXTSEL_BIT = 1;
	localparam int STAT_ARMED_BIT = 0;
	localparam int STAT_TRIG_BIT = 1;
	localparam int STAT_RUN_LSB = 4;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [1:0] RT_LATENCY = 2'h3;

	typedef struct packed {
		logic [NCH-1:0][7:0] gap;
		logic [NCH-1:0][7:0] nlen;
		logic [NCH-1:0][7:0] func;
		logic [NCH-1:0][7:0] rtc;
		logic [NCH-1:0][7:0] req;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [NCH-1:0] src_prev;
		logic [NCH-1:0] armed;
		logic [NCH-1:0] rtrg;
		logic [NCH-1:0][1:0] rcnt;
		logic [NG-1:0] trg_prev;
		logic [NG-1:0] pend;
		logic [NG-1:0] run;
		logic [NG-1:0] gate;
		logic [NG-1:0] outq;
		logic [NG-1:0][POSW-1:0] pos;
	} gbc_top_s;

	typedef struct packed {
		logic [NCH-1:0] s1;
		logic [NCH-1:0] s2;
	} gbc_sync_s;

endpackage : gbc_pkg

/* hw/gbc_sync.sv */
// Purpose: Two-stage synchronizer for the external trigger pins.
// Assumes: One trigger pin per channel.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/100ps
`default_nettype none

module gbc_sync (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [gbc_pkg::NCH-1:0] pin_in,
	output logic [gbc_pkg::NCH-1:0] pin_sync
);

	gbc_pkg::gbc_sync_s st_r;
	gbc_pkg::gbc_sync_s st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = pin_in;
		st_nxt.s2 = st_r.s1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pin_sync = st_r.s2;

endmodule : gbc_sync

`default_nettype wire

/* hw/gbc_top.sv */
// Purpose: Gapped and burst clock pattern generators with an APB register file.
// Assumes: Divider rising edges arrive as one-cycle pulses on div_tick and divider levels on
//   div_level, both synchronous to pclk.
// Notes: Randomized clock selection drives the output low; that generator lives elsewhere.
// Function
// - Generators step once per divider cycle.
// - Trigger from request bit or pin.
// - Segment, mode, retime settings shared per channel.
// - Clock segment then gap, six/eight bits.
// - Zero clock means none; zero gap one.
// - Mode bit picks burst or periodic.
// - Burst starts only on trigger rise.
// - Burst emits clocks, gap, then stays low.
// - Periodic repeats pattern while trigger high.
// - Trigger low stalls after current pulse.
// - Periodic resumes from saved position.
// - Retime bit selects direct or retimed.
// - Direct trigger passes through unaligned.
// - Retimer armed by rise, fires slowest edge.
// - Retimed trigger after three slowest edges.
// - Slowest is enabled divider with largest phase.
// - Function decode normal, burst, random; never both.
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module gbc_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [gbc_pkg::NCH-1:0] ext_trigger_pins,
	input wire logic [gbc_pkg::NG-1:0] div_tick,
	input wire logic [gbc_pkg::NG-1:0] div_level,
	input wire logic [gbc_pkg::NG*gbc_pkg::PHW-1:0] div_phase,
	output logic [gbc_pkg::NG-1:0] pattern_out
);

	gbc_pkg::gbc_top_s st_r;
	gbc_pkg::gbc_top_s st_nxt;
	logic [gbc_pkg::NCH-1:0] ext_sync;

	gbc_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in(ext_trigger_pins),
		.pin_sync(ext_sync)
	);

	always_comb begin
		logic [gbc_pkg::IDXW-1:0] idx;
		logic aligned;
		logic hit;
		logic src;
		logic trig;
		logic found;
		logic slow_tick;
		logic [gbc_pkg::PHW-1:0] best_ph;
		logic [gbc_pkg::PHW-1:0] ph;
		int best;
		int g;
		logic burst_en;
		logic rand_en;
		logic periodic;
		logic [gbc_pkg::POSW-1:0] nseg;
		logic [gbc_pkg::POSW-1:0] gseg;
		logic [gbc_pkg::POSW-1:0] last;
		logic [gbc_pkg::POSW-1:0] p;
		logic go;
		idx = paddr[15:2];
		aligned = (paddr[1:0] == 2'h0);
		hit = 1'b0;
		src = 1'b0;
		trig = 1'b0;
		found = 1'b0;
		slow_tick = 1'b0;
		best_ph = '0;
		ph = '0;
		best = 0;
		g = 0;
		burst_en = 1'b0;
		rand_en = 1'b0;
		periodic = 1'b0;
		nseg = '0;
		gseg = '0;
		last = '0;
		p = '0;
		go = 1'b0;
		st_nxt = st_r;
		st_nxt.pready = 1'b0;
		st_nxt.pslverr = 1'b0;

		// Setup phase: decode and prepare the answer for the access phase.
		if (psel && !penable) begin
			st_nxt.pready = 1'b1;
			st_nxt.prdata = '0;
			for (int c = 0; c < gbc_pkg::NCH; c++) begin
				if (aligned && idx == gbc_pkg::IDX_GAP[c]) begin
					hit = 1'b1;
					st_nxt.prdata[7:0] = st_r.gap[c];
				end
				if (aligned && idx == gbc_pkg::IDX_LEN[c]) begin
					hit = 1'b1;
					st_nxt.prdata[7:0] = st_r.nlen[c];
				end
				if (aligned && idx == gbc_pkg::IDX_FUNC[c]) begin
					hit = 1'b1;
					st_nxt.prdata[7:0] = st_r.func[c];
				end
				if (aligned && idx == gbc_pkg::IDX_RTC[c]) begin
					hit = 1'b1;
					st_nxt.prdata[7:0] = st_r.rtc[c];
				end
				if (aligned && idx == gbc_pkg::IDX_REQ[c]) begin
					hit = 1'b1;
					st_nxt.prdata[7:0] = st_r.req[c];
				end
				if (aligned && idx == gbc_pkg::IDX_STAT[c]) begin
					hit = 1'b1;
					st_nxt.prdata[gbc_pkg::STAT_ARMED_BIT] = st_r.armed[c];
					st_nxt.prdata[gbc_pkg::STAT_TRIG_BIT] = st_r.rtrg[c];
					st_nxt.prdata[gbc_pkg::STAT_RUN_LSB +: gbc_pkg::NOUT] =
						st_r.run[c*gbc_pkg::NOUT +: gbc_pkg::NOUT];
				end
			end
			if (!hit) begin
				st_nxt.pslverr = 1'b1;
				st_nxt.prdata = '0;
			end
		end

		// Access phase: a write lands at the edge that samples pready.
		if (psel && penable && st_r.pready && pwrite && !st_r.pslverr) begin
			for (int c = 0; c < gbc_pkg::NCH; c++) begin
				if (idx == gbc_pkg::IDX_GAP[c]) begin
					st_nxt.gap[c] = pwdata[7:0];
				end
				if (idx == gbc_pkg::IDX_LEN[c]) begin
					st_nxt.nlen[c] = pwdata[7:0];
				end
				if (idx == gbc_pkg::IDX_FUNC[c]) begin
					st_nxt.func[c] = pwdata[7:0];
				end
				if (idx == gbc_pkg::IDX_RTC[c]) begin
					st_nxt.rtc[c] = pwdata[7:0];
				end
				if (idx == gbc_pkg::IDX_REQ[c]) begin
					st_nxt.req[c] = pwdata[7:0];
				end
			end
		end

		for (int c = 0; c < gbc_pkg::NCH; c++) begin
			src = st_r.req[c][gbc_pkg::EXTSEL_BIT] ? ext_sync[c] :
				st_r.req[c][gbc_pkg::REQ_BIT];
			st_nxt.src_prev[c] = src;

			// pick largest phase among burst-enabled outputs
			found = 1'b0;
			best = 0;
			best_ph = '0;
			for (int o = 0; o < gbc_pkg::NOUT; o++) begin
				g = c * gbc_pkg::NOUT + o;
				ph = div_phase[g*gbc_pkg::PHW +: gbc_pkg::PHW];
				if (st_r.func[c][2*o] && !st_r.func[c][2*o+1] &&
					(!found || ph > best_ph)) begin
					found = 1'b1;
					best = o;
					best_ph = ph;
				end
			end
			slow_tick = found && div_tick[c*gbc_pkg::NOUT + best];

			if (st_r.rtc[c][gbc_pkg::RETIME_BIT]) begin
				// A fired trigger stays high while the source does; a new firing wins.
				if (st_r.rtrg[c] && !src) begin
					st_nxt.rtrg[c] = 1'b0;
				end
				// arm on rise, fire on slowest edge
				if (src && !st_r.src_prev[c]) begin
					st_nxt.armed[c] = 1'b1;
					st_nxt.rcnt[c] = 2'h0;
				end else if (st_r.armed[c] && slow_tick) begin
					// fire on the third slowest edge
					if (st_r.rcnt[c] == gbc_pkg::RT_LATENCY - 2'h1) begin
						st_nxt.armed[c] = 1'b0;
						st_nxt.rcnt[c] = 2'h0;
						st_nxt.rtrg[c] = 1'b1;
					end else begin
						st_nxt.rcnt[c] = st_r.rcnt[c] + 2'h1;
					end
				end
				trig = st_r.rtrg[c];
			end else begin
				st_nxt.armed[c] = 1'b0;
				st_nxt.rcnt[c] = 2'h0;
				st_nxt.rtrg[c] = 1'b0;
				trig = src;
			end

			// one set of pattern settings per channel
			periodic = st_r.nlen[c][gbc_pkg::MODE_BIT];
			nseg = gbc_pkg::POSW'(st_r.nlen[c][gbc_pkg::LEN_W-1:0]);
			// zero gap counts as one cycle
			gseg = (st_r.gap[c] == 8'h00) ? 9'h001 : gbc_pkg::POSW'(st_r.gap[c]);
			last = nseg + gseg - 9'h001;

			for (int o = 0; o < gbc_pkg::NOUT; o++) begin
				g = c * gbc_pkg::NOUT + o;
				burst_en = st_r.func[c][2*o] && !st_r.func[c][2*o+1];
				rand_en = st_r.func[c][2*o+1];
				st_nxt.trg_prev[g] = trig;

				// generators step on their own divider edge
				if (div_tick[g]) begin
					if (periodic) begin
						st_nxt.pend[g] = 1'b0;
						if (trig) begin
							st_nxt.run[g] = 1'b1;
							st_nxt.gate[g] = (st_r.pos[g] < nseg);
							st_nxt.pos[g] = (st_r.pos[g] == last) ? 9'h000 :
								st_r.pos[g] + 9'h001;
						end else begin
							st_nxt.run[g] = 1'b0;
							st_nxt.gate[g] = 1'b0;
						end
					end else begin
						// one pass of clock and gap
						go = st_r.run[g] || st_r.pend[g];
						p = st_r.run[g] ? st_r.pos[g] : 9'h000;
						if (go) begin
							st_nxt.pend[g] = st_r.run[g] && st_r.pend[g];
							st_nxt.gate[g] = (p < nseg);
							if (p == last) begin
								st_nxt.run[g] = 1'b0;
								st_nxt.pos[g] = 9'h000;
							end else begin
								st_nxt.run[g] = 1'b1;
								st_nxt.pos[g] = p + 9'h001;
							end
						end else begin
							st_nxt.gate[g] = 1'b0;
						end
					end
				end

				// only a rising trigger starts a burst
				if (!periodic && trig && !st_r.trg_prev[g]) begin
					st_nxt.pend[g] = 1'b1;
				end

				if (!burst_en) begin
					st_nxt.pend[g] = 1'b0;
					st_nxt.run[g] = 1'b0;
					st_nxt.gate[g] = 1'b0;
					st_nxt.pos[g] = 9'h000;
				end

				if (burst_en) begin
					st_nxt.outq[g] = st_nxt.gate[g] && div_level[g];
				end else if (rand_en) begin
					st_nxt.outq[g] = 1'b0;
				end else begin
					st_nxt.outq[g] = div_level[g];
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
			for (int c = 0; c < gbc_pkg::NCH; c++) begin
				st_r.gap[c] <= gbc_pkg::REG_RST;
				st_r.nlen[c] <= gbc_pkg::REG_RST;
				st_r.func[c] <= gbc_pkg::REG_RST;
				st_r.rtc[c] <= gbc_pkg::REG_RST;
				st_r.req[c] <= gbc_pkg::REG_RST;
			end
		end else begin
			st_r <= st_nxt;
		end
	end

	assign prdata = st_r.prdata;
	assign pready = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign pattern_out = st_r.outq;

endmodule : gbc_top

`default_nettype wire

/* sim/gbc_div_model.sv */
// Purpose: Divider model feeding the generator divider inputs.
// Assumes: All outputs divide by DIV with aligned rising edges.
// Notes: Output g has phase g, so output 3 of a channel is slowest.
`timescale 1ns/100ps
`default_nettype none
module gbc_div_model #(
	parameter int DIV = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	output logic [gbc_pkg::NG-1:0] div_tick,
	output logic [gbc_pkg::NG-1:0] div_level,
	output logic [gbc_pkg::NG*gbc_pkg::PHW-1:0] div_phase
);
	int cnt;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt <= 0;
		else
			cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
	end
	assign div_tick = {gbc_pkg::NG{cnt == 0}};
	assign div_level = {gbc_pkg::NG{cnt < DIV / 2}};
	// phase only ranks the outputs; all rising edges coincide.
	for (genvar g = 0; g < gbc_pkg::NG; g++) begin : ph
		assign div_phase[g*gbc_pkg::PHW +: gbc_pkg::PHW] = gbc_pkg::PHW'(g);
	end
endmodule : gbc_div_model
`default_nettype wire

/* sim/gbc_top_properties.sv */
// Purpose: Bus and output timing checks for the generator.
// Assumes: Bound to gbc_top.
// Notes: Sees only top ports.
`timescale 1ns/100ps
`default_nettype none
module gbc_top_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [gbc_pkg::NG-1:0] div_tick,
	input wire logic [gbc_pkg::NG-1:0] div_level,
	input wire logic [gbc_pkg::NG-1:0] pattern_out
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	chk_ready_setup: assert property (psel && !penable |=> pready)
		else $error("no pready after setup");
	chk_ready_once: assert property (pready |=> !pready)
		else $error("pready too long");
	chk_ready_access: assert property (pready |-> psel && penable)
		else $error("pready outside access");
	chk_err_answer: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("bad error answer");
	chk_data_high: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	chk_reset_quiet: assert property (disable iff (1'b0)
		!presetn |-> pattern_out == '0 && !pready)
		else $error("outputs active in reset");
	for (genvar g = 0; g < gbc_pkg::NG; g++) begin : per_out
		chk_out_level: assert property (pattern_out[g] |-> $past(div_level[g]))
			else $error("output high while divider low");
		chk_out_rise: assert property ($rose(pattern_out[g]) |->
			$past(div_tick[g]) || $past(div_tick[g], 2))
			else $error("output rise not after divider edge");
	end
	cover property (pslverr);
	cover property ($rose(pattern_out[0]));
	cover property ($rose(pattern_out[6]));
endmodule : gbc_top_properties
bind gbc_top gbc_top_properties u_chk (.pclk, .presetn, .psel, .penable, .prdata,
	.pready, .pslverr, .div_tick, .div_level, .pattern_out);
`default_nettype wire

/* sim/gbc_top_tb_top.sv */
// Purpose: Self-checking bench for the generator.
// Assumes: Divider model at ratio 32.
// Notes: Pulses are counted as rising edges of each output.
`timescale 1ns/100ps
`default_nettype none
module gbc_top_tb_top;
	localparam int DIV = 32;
	logic pclk = 0, presetn = 1, psel = 0, penable = 0, pwrite = 0;
	logic [15:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, e;
	logic [1:0] ext_trigger_pins = '0;
	logic [7:0] div_tick, div_level, pattern_out, prev = '0;
	logic [63:0] div_phase;
	int rises[8], miscompares = 0, check_count = 0;
	gbc_top u_gbc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .ext_trigger_pins, .div_tick, .div_level,
		.div_phase, .pattern_out);
	gbc_div_model #(.DIV(DIV)) u_gbc_div_model (.pclk, .presetn, .div_tick,
		.div_level, .div_phase);
	initial forever #5 pclk = ~pclk;
	always @(posedge pclk) begin
		for (int g = 0; g < 8; g++)
			if (pattern_out[g] && !prev[g]) rises[g]++;
		prev = pattern_out;
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [13:0] idx, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task automatic rdchk(input logic [13:0] idx, input logic [7:0] exp);
		apb(0, idx, 8'h00);
		chk(rd, {24'h0, exp});
	endtask : rdchk
	task automatic wait_div(input int n);
		repeat (n * DIV) @(posedge pclk);
	endtask : wait_div
	function automatic int plen(input int n, input int g);
		return n + ((g == 0) ? 1 : g);
	endfunction : plen
	task automatic burst(input int c, input int n, input int g, input logic rt, input logic ext);
		int b[8];
		apb(1, gbc_pkg::IDX_GAP[c], 8'(g));
		apb(1, gbc_pkg::IDX_LEN[c], 8'(n));
		apb(1, gbc_pkg::IDX_RTC[c], {7'h0, rt});
		apb(1, gbc_pkg::IDX_FUNC[c], 8'h19);
		// Counts start once the new function selection has reached the outputs.
		repeat (2) @(posedge pclk);
		b = rises;
		if (ext) begin
			apb(1, gbc_pkg::IDX_REQ[c], 8'h02);
			ext_trigger_pins[c] <= 1'b1;
			wait_div(1);
			ext_trigger_pins[c] <= 1'b0;
			apb(1, gbc_pkg::IDX_REQ[c], 8'h00);
		end else begin
			apb(1, gbc_pkg::IDX_REQ[c], 8'h01);
			apb(1, gbc_pkg::IDX_REQ[c], 8'h00);
		end
		wait_div(2);
		if (rt) chk(32'(rises[4*c] - b[4*c]), 0);
		wait_div(plen(n, g) + 6);
		chk(32'(rises[4*c] - b[4*c]), 32'(n));
		chk(32'(rises[4*c+2] - b[4*c+2]), 32'(n));
		chk(32'(rises[4*c+1] - b[4*c+1]), 0);
		chk(32'(rises[4*c+3] > b[4*c+3]), 1);
	endtask : burst
	task automatic periodic(input int c);
		int b;
		apb(1, gbc_pkg::IDX_RTC[c], 8'h00);
		apb(1, gbc_pkg::IDX_LEN[c], 8'h42);
		apb(1, gbc_pkg::IDX_GAP[c], 8'h03);
		// The second pass resumes from the position saved by the first stall.
		for (int k = 0; k < 2; k++) begin
			b = rises[4*c];
			apb(1, gbc_pkg::IDX_REQ[c], 8'h01);
			wait_div(20);
			apb(1, gbc_pkg::IDX_REQ[c], 8'h00);
			wait_div(3);
			b = rises[4*c] - b - (20 / plen(2, 3)) * 2;
			chk(32'(b >= -2 && b <= 2), 1);
			b = rises[4*c];
			wait_div(10);
			chk(32'(rises[4*c] - b), 0);
		end
	endtask : periodic
	initial begin
		#400000;
		miscompares++;
		report_and_stop();
	end
	initial begin
		presetn <= 1'b0;
		void'($urandom(70542));
		repeat (20) @(posedge pclk);
		presetn <= 1;
		for (int c = 0; c < 2; c++) begin
			rdchk(gbc_pkg::IDX_GAP[c], 8'h00);
			rdchk(gbc_pkg::IDX_LEN[c], 8'h00);
			rdchk(gbc_pkg::IDX_FUNC[c], 8'h00);
			rdchk(gbc_pkg::IDX_STAT[c], 8'h00);
			rdchk(gbc_pkg::IDX_RTC[c], 8'h00);
			rdchk(gbc_pkg::IDX_REQ[c], 8'h00);
			pwdata <= 32'($urandom);
			@(posedge pclk);
			apb(1, gbc_pkg::IDX_GAP[c], pwdata[7:0]);
			rdchk(gbc_pkg::IDX_GAP[c], pwdata[7:0]);
		end
		apb(0, 14'h0001, 8'h00);
		chk({31'h0, e}, 1);
		chk(rd, 0);
		for (int c = 0; c < 2; c++) begin
			burst(c, 0, 0, 0, 0);
			burst(c, 1, 0, 1, 0);
			burst(c, 63, $urandom_range(0, 15), 0, 1);
			burst(c, $urandom_range(1, 62), $urandom_range(0, 15), 1'($urandom), 0);
			periodic(c);
		end
		report_and_stop();
	end
endmodule : gbc_top_tb_top
`default_nettype wire
